// ===== verilog/hpa_map.svh
// Operation
// RL1 - Four read kinds, bounded by select or strobe
// RL2 - Register writes and transmit FIFO writes
// RL3 - Transmit level updates within 135 ns
// RL4 - Host waits after writes, per read register
// RL5 - Waits: 315, 180, 135 ns groups
// RL6 - Interrupt status read waits 90 ns
// RL7 - Control register reads wait 45 ns
// RL8 - Some registers readable right after writes
// RL9 - Dummy byte-order reads may fill waits
// RL10 - Slower hosts need fewer dummy reads
// RL11 - Waits between side-effect read pairs
// RL12 - Read side effects may appear late
// RL13 - Read spans select and strobe both low
// RL14 - Upper data half undriven in 16-bit mode
// RL15 - FIFO select reads receive data, keeps A2:1
// RL16 - Host stalls reads with age counters
`ifndef HPA_MAP_SVH
`define HPA_MAP_SVH
`define HPA_CLK_NS 40
`define HPA_NS2CYC(ns) (((ns) + `HPA_CLK_NS - 1) / `HPA_CLK_NS)
`define HPA_OFF_RX_DATA 8'h00
`define HPA_OFF_TX_DATA 8'h20
`define HPA_OFF_TX_DATA_END 8'h3C
`define HPA_OFF_REG_BASE 8'h50
`define HPA_OFF_IDENT 8'h50
`define HPA_OFF_IRQ_PIN 8'h54
`define HPA_OFF_INT_STAT 8'h58
`define HPA_OFF_INT_ENA 8'h5C
`define HPA_OFF_BYTE_ORDER 8'h64
`define HPA_OFF_FIFO_LVL_INT 8'h68
`define HPA_OFF_RX_CONF 8'h6C
`define HPA_OFF_TX_CONF 8'h70
`define HPA_OFF_HW_CONF 8'h74
`define HPA_OFF_RX_PATH 8'h78
`define HPA_OFF_RX_LEVEL 8'h7C
`define HPA_OFF_TX_LEVEL 8'h80
`define HPA_OFF_POWER 8'h84
`define HPA_OFF_GPIO_CONF 8'h88
`define HPA_OFF_TIMER_CONF 8'h8C
`define HPA_OFF_TIMER_CNT 8'h90
`define HPA_OFF_HALF_SWAP 8'h98
`define HPA_OFF_FREE_CNT 8'h9C
`define HPA_OFF_RX_DROPS 8'hA0
`define HPA_OFF_MAC_CMD 8'hA4
`define HPA_OFF_MAC_DATA 8'hA8
`define HPA_OFF_FLOW_CONF 8'hAC
`define HPA_OFF_EE_CMD 8'hB0
`define HPA_OFF_EE_DATA 8'hB4
`define HPA_OFF_RX_STAT 8'h40
`define HPA_OFF_TX_STAT 8'h48
`define HPA_BYTE_ORDER_VAL 32'hA5C3_0F96
`define HPA_WAIT_A_NS 315
`define HPA_WAIT_B_NS 180
`define HPA_WAIT_C_NS 135
`define HPA_WAIT_D_NS 90
`define HPA_WAIT_E_NS 45
`define HPA_TX_LVL_NS 135
`define HPA_TX_LVL_CYC ((`HPA_TX_LVL_NS) / `HPA_CLK_NS)
`define HPA_STROBE_CYC 2
`endif

// ===== verilog/hpa_pkg.sv
package hpa_pkg;
	typedef enum logic [1:0] {HPA_ST_IDLE, HPA_ST_HOLD, HPA_ST_STB, HPA_ST_GAP} hpa_hstate_t;
	typedef enum logic [1:0] {HPA_SIDE_NONE, HPA_SIDE_RXF, HPA_SIDE_TXS, HPA_SIDE_DROP} hpa_side_t;
	typedef logic [3:0] hpa_age_t;
	typedef logic [6:0] hpa_addr_t;
	typedef logic [31:0] hpa_word_t;
endpackage

// ===== verilog/hpa_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpa_if;
	import hpa_pkg::*;
	logic chip_select_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic fifo_select;
	hpa_addr_t addr;
	hpa_word_t host_data;
	logic host_data_oe;
	hpa_word_t dev_data;
	logic dev_data_oe_lo;
	logic dev_data_oe_hi;
	modport host (output chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
		host_data, host_data_oe, input dev_data, dev_data_oe_lo, dev_data_oe_hi);
	modport dev (input chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
		host_data, host_data_oe, output dev_data, dev_data_oe_lo, dev_data_oe_hi);
endinterface
`default_nettype wire

// ===== verilog/hpa_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "hpa_map.svh"
module hpa_dev #(
	parameter logic [31:0] IDENT_VAL = 32'h0000_0001, // Arbitrary identity value
	parameter bit BUS16 = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	hpa_if.dev bus,
	input wire hpa_pkg::hpa_word_t i_rx_data,
	input wire logic [15:0] i_rx_level,
	input wire logic i_rx_drop,
	input wire logic i_tx_drain,
	output logic o_rx_pop,
	output logic o_tx_push,
	output hpa_pkg::hpa_word_t o_tx_data,
	output logic [15:0] o_tx_level
);
	import hpa_pkg::*;
	localparam int TXC = `HPA_TX_LVL_CYC;
	typedef struct packed {
		logic rd_act;
		logic rd_fifo;
		hpa_addr_t raddr;
		logic wr_act;
		logic wr_fifo;
		hpa_addr_t waddr;
		hpa_word_t wdata;
		hpa_word_t dout;
		logic oe_lo;
		logic oe_hi;
		logic [63:0][31:0] mem;
		logic [TXC-2:0] tx_pipe;
		logic [15:0] tx_lvl;
		logic [15:0] rx_lvl;
		logic [15:0] drops;
		logic tx_push;
		hpa_word_t tx_data;
		logic rx_pop;
	} hpa_dev_s_t;
	hpa_dev_s_t r_reg, r_next;

	////////////////////////////////////////////////////////////////
	// Word seen by a read at a given byte offset
	function automatic hpa_word_t read_word(input logic [7:0] a, input logic fifo);
		hpa_word_t w;
		w = r_reg.mem[a[7:2]];
		if (fifo || a < `HPA_OFF_TX_DATA) begin
			w = i_rx_data; // RL15
		end else begin
			unique case (a)
				`HPA_OFF_IDENT: w = IDENT_VAL; // RL8
				`HPA_OFF_BYTE_ORDER: w = `HPA_BYTE_ORDER_VAL; // RL8
				`HPA_OFF_RX_LEVEL: w = {16'h0000, r_reg.rx_lvl}; // RL8
				`HPA_OFF_RX_DROPS: w = {16'h0000, r_reg.drops}; // RL8
				`HPA_OFF_TX_LEVEL: w = {16'h0000, r_reg.tx_lvl};
				default: w = r_reg.mem[a[7:2]];
			endcase
		end
		return w;
	endfunction

	function automatic logic read_only(input logic [7:0] a);
		return a == `HPA_OFF_IDENT || a == `HPA_OFF_BYTE_ORDER || a == `HPA_OFF_RX_LEVEL
			|| a == `HPA_OFF_TX_LEVEL || a == `HPA_OFF_RX_DROPS;
	endfunction

	////////////////////////////////////////////////////////////////
	logic rd_on;
	logic wr_on;
	logic [7:0] rbyte;
	logic [7:0] wbyte;
	hpa_word_t rw;
	assign rd_on = !bus.chip_select_n && !bus.read_strobe_n; // RL13
	assign wr_on = !bus.chip_select_n && !bus.write_strobe_n; // RL2
	// FIFO select drops A7:3 but keeps A2:1
	assign rbyte = bus.fifo_select ? {5'h00, bus.addr[1:0], 1'b0} : {bus.addr, 1'b0}; // RL15
	assign wbyte = {r_reg.waddr, 1'b0};
	assign rw = read_word(rbyte, bus.fifo_select);

	// Next state of the whole port
	always_comb begin
		r_next = r_reg;
		r_next.tx_push = 1'b0;
		r_next.rx_pop = 1'b0;
		r_next.rx_lvl = i_rx_level; // RL12
		r_next.rd_act = rd_on;
		r_next.wr_act = wr_on;
		// Reads: each cycle re-decodes, so bursts follow the address
		if (rd_on) begin // RL1
			r_next.raddr = rbyte[7:1];
			r_next.rd_fifo = bus.fifo_select || rbyte < `HPA_OFF_TX_DATA;
			if (BUS16) begin
				r_next.dout = {16'h0000, rbyte[1] ? rw[31:16] : rw[15:0]};
			end else begin
				r_next.dout = rw;
			end
			r_next.oe_lo = 1'b1;
			r_next.oe_hi = !BUS16; // RL14
		end else begin
			r_next.oe_lo = 1'b0;
			r_next.oe_hi = 1'b0;
		end
		// One FIFO word per read, popped at its end or address step
		if (r_reg.rd_act && r_reg.rd_fifo && (!rd_on || rbyte[7:1] != r_reg.raddr)) begin // RL1
			r_next.rx_pop = 1'b1; // RL12
		end
		// Drop counter clears as a read side effect
		if (r_reg.rd_act && !rd_on && {r_reg.raddr, 1'b0} == `HPA_OFF_RX_DROPS) begin
			r_next.drops = 16'h0000;
		end else if (i_rx_drop && r_reg.drops != 16'hFFFF) begin
			r_next.drops = r_reg.drops + 16'h0001;
		end
		// Writes latch while active and commit on release
		if (wr_on) begin
			r_next.waddr = bus.addr;
			r_next.wr_fifo = bus.fifo_select;
			r_next.wdata = bus.host_data;
		end
		// Push cycle is already one step, so the pipe is one short
		r_next.tx_pipe = r_reg.tx_pipe << 1;
		if (r_reg.wr_act && !wr_on) begin
			if (r_reg.wr_fifo || (wbyte >= `HPA_OFF_TX_DATA && wbyte <= `HPA_OFF_TX_DATA_END + 8'h03)) begin
				r_next.tx_push = 1'b1; // RL2
				r_next.tx_data = r_reg.wdata;
				r_next.tx_pipe[0] = 1'b1; // RL3
			end else if (wbyte >= `HPA_OFF_REG_BASE && !read_only(wbyte)) begin
				if (BUS16 && wbyte[1]) begin
					r_next.mem[wbyte[7:2]][31:16] = r_reg.wdata[15:0];
				end else if (BUS16) begin
					r_next.mem[wbyte[7:2]][15:0] = r_reg.wdata[15:0];
				end else begin
					r_next.mem[wbyte[7:2]] = r_reg.wdata;
				end
			end
		end
		// Level catches up a fixed few cycles after the write
		r_next.tx_lvl = r_reg.tx_lvl + {15'h0000, r_reg.tx_pipe[TXC-2]} // RL3
			- {15'h0000, i_tx_drain && r_reg.tx_lvl != 16'h0000};
	end

	// Single register for all state
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus.dev_data = r_reg.dout;
	assign bus.dev_data_oe_lo = r_reg.oe_lo;
	assign bus.dev_data_oe_hi = r_reg.oe_hi;
	assign o_rx_pop = r_reg.rx_pop;
	assign o_tx_push = r_reg.tx_push;
	assign o_tx_data = r_reg.tx_data;
	assign o_tx_level = r_reg.tx_lvl;
endmodule
`default_nettype wire

// ===== verilog/hpa_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "hpa_map.svh"
module hpa_host #(
	parameter bit BUS16 = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	hpa_if.host bus,
	input wire logic i_req,
	input wire logic i_req_wr,
	input wire logic [7:0] i_req_addr,
	input wire logic i_req_fifo,
	input wire hpa_pkg::hpa_word_t i_req_wdata,
	output logic o_ready,
	output logic o_rvalid,
	output hpa_pkg::hpa_word_t o_rdata
);
	import hpa_pkg::*;

	////////////////////////////////////////////////////////////////
	// Wait lengths in clock cycles, rounded up
	localparam hpa_age_t W_A = 4'(`HPA_NS2CYC(`HPA_WAIT_A_NS));
	localparam hpa_age_t W_B = 4'(`HPA_NS2CYC(`HPA_WAIT_B_NS));
	localparam hpa_age_t W_C = 4'(`HPA_NS2CYC(`HPA_WAIT_C_NS));
	localparam hpa_age_t W_D = 4'(`HPA_NS2CYC(`HPA_WAIT_D_NS));
	localparam hpa_age_t W_E = 4'(`HPA_NS2CYC(`HPA_WAIT_E_NS));
	localparam hpa_age_t STB = 4'(`HPA_STROBE_CYC - 1);

	typedef struct packed {
		hpa_hstate_t st;
		logic wr;
		logic fifo;
		logic [7:0] addr;
		hpa_word_t wdata;
		hpa_age_t stb_cnt;
		hpa_age_t wr_age;
		hpa_age_t side_age;
		hpa_side_t side;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic data_oe;
		logic ready;
		logic rvalid;
		hpa_word_t rdata;
	} hpa_host_s_t;
	hpa_host_s_t r_reg, r_next;

	////////////////////////////////////////////////////////////////
	// Least wait after any write, chosen by the register read
	function automatic hpa_age_t raw_wait(input logic [7:0] a, input logic fifo);
		hpa_age_t w;
		w = 4'h0;
		if (!fifo) begin // RL4
			unique case (a)
				`HPA_OFF_POWER: w = W_A; // RL5
				`HPA_OFF_FREE_CNT: w = W_B; // RL5
				`HPA_OFF_IRQ_PIN,
				`HPA_OFF_TX_LEVEL,
				`HPA_OFF_TIMER_CNT: w = W_C; // RL5
				`HPA_OFF_INT_STAT: w = W_D; // RL6
				`HPA_OFF_INT_ENA,
				`HPA_OFF_FIFO_LVL_INT,
				`HPA_OFF_RX_CONF,
				`HPA_OFF_TX_CONF,
				`HPA_OFF_HW_CONF,
				`HPA_OFF_RX_PATH,
				`HPA_OFF_GPIO_CONF,
				`HPA_OFF_TIMER_CONF,
				`HPA_OFF_HALF_SWAP,
				`HPA_OFF_MAC_CMD,
				`HPA_OFF_MAC_DATA,
				`HPA_OFF_FLOW_CONF,
				`HPA_OFF_EE_CMD,
				`HPA_OFF_EE_DATA: w = W_E; // RL7
				default: w = 4'h0; // RL8
			endcase
		end
		return w;
	endfunction

	// Which side effect a read leaves behind
	function automatic hpa_side_t side_of(input logic [7:0] a, input logic fifo);
		hpa_side_t s;
		s = HPA_SIDE_NONE;
		if (fifo || a < `HPA_OFF_TX_DATA) begin
			s = HPA_SIDE_RXF;
		end else if (a == `HPA_OFF_RX_STAT) begin
			s = HPA_SIDE_RXF;
		end else if (a == `HPA_OFF_TX_STAT) begin
			s = HPA_SIDE_TXS;
		end else if (a == `HPA_OFF_RX_DROPS) begin
			s = HPA_SIDE_DROP;
		end
		return s;
	endfunction

	// Least wait after a side-effect read, by pair
	function automatic hpa_age_t rar_wait(input hpa_side_t s, input logic [7:0] a, input logic fifo);
		hpa_age_t w;
		w = 4'h0;
		if (!fifo) begin // RL11
			if (s == HPA_SIDE_RXF && a == `HPA_OFF_RX_LEVEL) begin
				w = W_C;
			end else if (s == HPA_SIDE_TXS && a == `HPA_OFF_TX_LEVEL) begin
				w = W_C;
			end else if (s == HPA_SIDE_DROP && a == `HPA_OFF_RX_DROPS) begin
				w = W_B;
			end
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////
	// Reads stall while either age is short of its wait; writes never stall
	logic stall;
	assign stall = !r_reg.wr && (r_reg.wr_age < raw_wait(r_reg.addr, r_reg.fifo) // RL16
		|| r_reg.side_age < rar_wait(r_reg.side, r_reg.addr, r_reg.fifo)); // RL16

	// Next state
	always_comb begin
		r_next = r_reg;
		r_next.rvalid = 1'b0;
		// Ages count real time, so any access pattern counts
		if (r_reg.wr_age != 4'hF) begin
			r_next.wr_age = r_reg.wr_age + 4'h1; // RL10
		end
		if (r_reg.side_age != 4'hF) begin
			r_next.side_age = r_reg.side_age + 4'h1; // RL9
		end
		unique case (r_reg.st)
			HPA_ST_IDLE: begin
				if (i_req) begin
					r_next.wr = i_req_wr;
					r_next.fifo = i_req_fifo;
					r_next.addr = i_req_addr;
					r_next.wdata = i_req_wdata;
					r_next.ready = 1'b0;
					r_next.st = HPA_ST_HOLD;
				end
			end
			HPA_ST_HOLD: begin
				if (!stall) begin // RL16
					r_next.cs_n = 1'b0; // RL13
					r_next.rd_n = r_reg.wr;
					r_next.wr_n = !r_reg.wr; // RL2
					r_next.data_oe = r_reg.wr;
					r_next.stb_cnt = STB;
					r_next.st = HPA_ST_STB;
				end
			end
			HPA_ST_STB: begin
				if (r_reg.stb_cnt == 4'h0) begin
					// Release both; either ends the cycle
					r_next.cs_n = 1'b1; // RL1
					r_next.rd_n = 1'b1;
					r_next.wr_n = 1'b1;
					r_next.data_oe = 1'b0;
					if (r_reg.wr) begin
						r_next.wr_age = 4'h0; // RL4
					end else begin
						r_next.rvalid = 1'b1;
						if (BUS16) begin
							r_next.rdata = {16'h0000, bus.dev_data[15:0]};
						end else begin
							r_next.rdata = bus.dev_data;
						end
						if (side_of(r_reg.addr, r_reg.fifo) != HPA_SIDE_NONE) begin
							r_next.side = side_of(r_reg.addr, r_reg.fifo); // RL11
							r_next.side_age = 4'h0;
						end
					end
					r_next.st = HPA_ST_GAP;
				end else begin
					r_next.stb_cnt = r_reg.stb_cnt - 4'h1;
				end
			end
			HPA_ST_GAP: begin
				// One idle cycle meets the deassertion time
				r_next.ready = 1'b1;
				r_next.st = HPA_ST_IDLE;
			end
		endcase
	end

	// Single register for all state
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			r_reg <= '{st: HPA_ST_IDLE, side: HPA_SIDE_NONE, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				ready: 1'b1, wr_age: 4'hF, side_age: 4'hF, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pins and user outputs straight from the state register
	assign bus.chip_select_n = r_reg.cs_n;
	assign bus.read_strobe_n = r_reg.rd_n;
	assign bus.write_strobe_n = r_reg.wr_n;
	assign bus.fifo_select = r_reg.fifo;
	assign bus.addr = r_reg.addr[7:1];
	assign bus.host_data = r_reg.wdata;
	assign bus.host_data_oe = r_reg.data_oe;
	assign o_ready = r_reg.ready;
	assign o_rvalid = r_reg.rvalid;
	assign o_rdata = r_reg.rdata;
endmodule
`default_nettype wire

// ===== test/hpa_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "hpa_map.svh"
module hpa_link_properties #(
	parameter bit BUS16 = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic fifo_select,
	input wire hpa_pkg::hpa_addr_t addr,
	input wire logic host_data_oe,
	input wire hpa_pkg::hpa_word_t dev_data,
	input wire logic dev_data_oe_lo,
	input wire logic dev_data_oe_hi
);
	import hpa_pkg::*;
	typedef struct packed {
		logic [4:0] wage;
		logic [4:0] dage;
	} hpa_chk_t;
	hpa_chk_t chk_reg;
	hpa_chk_t chk_next;
	logic rd_act;
	logic wr_act;
	logic drop_rd;
	////////////////////////////////////////////////////////////////
	// A cycle only counts while select and strobe are both low
	assign rd_act = !chip_select_n && !read_strobe_n;
	assign wr_act = !chip_select_n && !write_strobe_n;
	assign drop_rd = rd_act && !fifo_select && addr == 7'h50;
	// Edges since last write and last drop read; saturate so no wrap
	always_comb begin
		chk_next = chk_reg;
		chk_next.wage = (chk_reg.wage == 5'h1F) ? 5'h1F : chk_reg.wage + 5'h01;
		chk_next.dage = (chk_reg.dage == 5'h1F) ? 5'h1F : chk_reg.dage + 5'h01;
		if (wr_act) chk_next.wage = 5'h00;
		if (drop_rd) chk_next.dage = 5'h00;
		if (i_reset) chk_next = {5'h1F, 5'h1F};
	end
	always_ff @(posedge i_clk_sys) begin
		chk_reg <= chk_next;
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	a_read_data_drive: assert property (rd_act |=> dev_data_oe_lo)
		else $error("device did not drive data during read");
	a_data_release: assert property (!rd_act |=> !dev_data_oe_lo && !dev_data_oe_hi)
		else $error("device still drives data after read ended");
	a_upper_half_lanes: assert property (rd_act |=> dev_data_oe_hi == !BUS16)
		else $error("upper data lanes driven wrongly");
	a_byte_order_value: assert property (!BUS16 && rd_act && !fifo_select && addr == 7'h32
		|=> dev_data == `HPA_BYTE_ORDER_VAL)
		else $error("byte order word wrong");
	a_write_data_drive: assert property (wr_act |-> host_data_oe)
		else $error("write strobe without host data");
	a_no_bus_fight: assert property (!(host_data_oe && dev_data_oe_lo))
		else $error("both ends drive data");
	a_power_read_wait: assert property (rd_act && !fifo_select && addr == 7'h42 |-> chk_reg.wage >= 5'd8)
		else $error("power register read too soon after write");
	a_status_read_wait: assert property (rd_act && !fifo_select && addr == 7'h2C |-> chk_reg.wage >= 5'd3)
		else $error("status read too soon after write");
	a_config_read_wait: assert property (rd_act && !fifo_select && addr == 7'h3A |-> chk_reg.wage >= 5'd2)
		else $error("config read too soon after write");
	a_drop_reread_wait: assert property ($rose(rd_act) && drop_rd |-> chk_reg.dage >= 5'd5)
		else $error("drop count read again too soon");
	cover property (rd_act && fifo_select);
	cover property (wr_act && fifo_select);
	cover property ($rose(rd_act) && drop_rd && chk_reg.dage >= 5'd5);
endmodule
`default_nettype wire

// ===== test/host_port_access_hazards_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "hpa_map.svh"
module host_port_access_hazards_bench;
	import hpa_pkg::*;
	localparam logic [31:0] IDENT = 32'h0000_1234; // Arbitrary identity value
	logic clk, reset, req, req_wr, req_fifo, rx_drop, tx_drain, ready, rvalid, rx_pop, tx_push;
	logic [7:0] req_addr;
	logic [15:0] rx_level, tx_level;
	logic [31:0] seed;
	logic [63:0] nt;
	hpa_word_t wdata, rx_data, rdata, tx_data;
	logic [63:0] rq[$];
	hpa_word_t tq[$];
	hpa_word_t v[3];
	logic [7:0] st[3] = '{8'h60, 8'h94, 8'hBC};
	logic [7:0] wt[9] = '{8'h84, 8'h9C, 8'h54, 8'h80, 8'h90, 8'h58, 8'h5C, 8'h74, 8'hB4};
	int mismatches, comparisons, tl_cd, tl_exp, pops, rx_reads;
	hpa_if link();
	hpa_host hpa_host_inst(.i_clk_sys(clk), .i_reset(reset), .bus(link.host), .i_req(req), .i_req_wr(req_wr),
		.i_req_addr(req_addr), .i_req_fifo(req_fifo), .i_req_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid),
		.o_rdata(rdata));
	hpa_dev #(.IDENT_VAL(IDENT)) hpa_dev_inst(.i_clk_sys(clk), .i_reset(reset), .bus(link.dev),
		.i_rx_data(rx_data), .i_rx_level(rx_level), .i_rx_drop(rx_drop), .i_tx_drain(tx_drain),
		.o_rx_pop(rx_pop), .o_tx_push(tx_push), .o_tx_data(tx_data), .o_tx_level(tx_level));
	hpa_link_properties hpa_link_properties_inst(.i_clk_sys(clk), .i_reset(reset),
		.chip_select_n(link.chip_select_n), .read_strobe_n(link.read_strobe_n),
		.write_strobe_n(link.write_strobe_n), .fifo_select(link.fifo_select), .addr(link.addr),
		.host_data_oe(link.host_data_oe), .dev_data(link.dev_data), .dev_data_oe_lo(link.dev_data_oe_lo),
		.dev_data_oe_hi(link.dev_data_oe_hi));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("Counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One request, noted for the monitor; waits for ready so inputs stay put
	task automatic xfer(input logic wr, input logic [7:0] a, input logic f, input logic [31:0] m,
		input logic [31:0] e);
		int n;
		req = 1'b1;
		req_wr = wr;
		req_addr = a;
		req_fifo = f;
		wdata = wr ? e : 32'h0000_0000;
		if (!wr) rq.push_back({m, e});
		if (wr && (f || (a >= 8'h20 && a < 8'h40))) tq.push_back(e);
		if (!wr && (f || a < 8'h20)) rx_reads++;
		@(negedge clk);
		req = 1'b0;
		n = 0;
		while (ready !== 1'b1 && n < 64) begin
			@(negedge clk);
			n++;
		end
		if (n == 64) mismatches++;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end
	// Results against the oldest note; level must show within the limit of the release
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			nt = rq.pop_front();
			check(rdata & nt[63:32], nt[31:0] & nt[63:32]);
		end
		if (tx_push === 1'b1) begin
			check(tx_data, tq.pop_front());
			tl_exp++;
			tl_cd = `HPA_TX_LVL_CYC - 1;
		end else if (tl_cd > 0) begin
			tl_cd--;
			if (tl_cd == 0) check({16'h0000, tx_level}, tl_exp);
		end
		if (rx_pop === 1'b1) pops++;
	end
	// Main sequence
	initial begin
		{reset, req, req_wr, req_fifo, rx_drop, tx_drain} = 6'h20;
		{req_addr, wdata, rx_data, rx_level} = '0;
		seed = 32'h2BECC066;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		foreach (st[i]) begin
			v[i] = rnd();
			xfer(1'b1, st[i], 1'b0, 32'h0, v[i]);
		end
		foreach (st[i]) xfer(1'b0, st[i], 1'b0, 32'hFFFFFFFF, v[i]);
		// Zero-wait registers straight after writes that they refuse
		xfer(1'b1, 8'h64, 1'b0, 32'h0, rnd());
		xfer(1'b0, 8'h64, 1'b0, 32'hFFFFFFFF, `HPA_BYTE_ORDER_VAL);
		xfer(1'b1, 8'h50, 1'b0, 32'h0, rnd());
		xfer(1'b0, 8'h50, 1'b0, 32'hFFFFFFFF, IDENT);
		// Every wait class read right after a write; the checker times gaps
		foreach (wt[i]) begin
			xfer(1'b1, 8'h60, 1'b0, 32'h0, rnd());
			// None of these words is ever written, so they read zero
			xfer(1'b0, wt[i], 1'b0, 32'hFFFFFFFF, 32'h0);
		end
		// Transmit words by window and by direct select, one drained
		xfer(1'b1, 8'h20, 1'b0, 32'h0, rnd());
		xfer(1'b1, 8'h3C, 1'b0, 32'h0, rnd());
		xfer(1'b1, 8'h00, 1'b1, 32'h0, rnd());
		repeat (6) @(negedge clk);
		tx_drain = 1'b1;
		tl_exp--;
		@(negedge clk);
		tx_drain = 1'b0;
		xfer(1'b1, 8'hC4, 1'b1, 32'h0, rnd());
		// Four pushes less one drain
		xfer(1'b0, 8'h80, 1'b0, 32'hFFFFFFFF, 32'h0000_0003);
		// Receive words; direct select ignores upper address bits
		for (int i = 0; i < 4; i++) begin
			rx_data = rnd();
			rx_level = 16'(rnd());
			xfer(1'b0, i[0] ? 8'(rnd()) & 8'hFE : 8'(rnd()) & 8'h1C, i[0], 32'hFFFFFFFF, rx_data);
			xfer(1'b0, 8'h7C, 1'b0, 32'hFFFFFFFF, {16'h0000, rx_level});
		end
		// Drop count read twice back to back
		rx_drop = 1'b1;
		@(negedge clk);
		rx_drop = 1'b0;
		// First read sees the one drop, second sees it cleared
		xfer(1'b0, 8'hA0, 1'b0, 32'hFFFFFFFF, 32'h0000_0001);
		xfer(1'b0, 8'hA0, 1'b0, 32'hFFFFFFFF, 32'h0000_0000);
		repeat (8) @(negedge clk);
		check(pops, rx_reads);
		check(rq.size(), 0);
		test_done();
	end
endmodule
`default_nettype wire
